/* pkg/pcr_params.svh */
`ifndef PCR_PARAMS_SVH
`define PCR_PARAMS_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define PCR_IDX_WAVE     6'h11
`define PCR_IDX_PAWK     6'h13
`define PCR_IDX_CMP      6'h17
`define PCR_IDX_PBWK     6'h18
`define PCR_IDX_TOUCH    6'h1d
`define PCR_IDX_STAT     6'h1f

// ----------------------------------------
// Writable bit masks and reset values
// ----------------------------------------
`define PCR_MASK_WAVE    8'h3f
`define PCR_MASK_WAKE    8'h7e
`define PCR_MASK_CMP     8'hf9
`define PCR_MASK_TOUCH   8'hf0
`define PCR_RST_WAVE     8'h00
`define PCR_RST_WAKE     8'h00
`define PCR_RST_CMP      8'h00
`define PCR_RST_TOUCH    8'hc0

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PCR_B_WAVE2_OE   5
`define PCR_B_WAVE_CKS   4
`define PCR_B_WAVE1_OE   3
`define PCR_B_WAVE0_OE   2
`define PCR_F_WAVE0_DIV  1:0
`define PCR_B_CMP_ON     7
`define PCR_B_CMP_EDGE   6
`define PCR_B_CMP_OE     5
`define PCR_F_CMP_NEG    4:3
`define PCR_B_CMP_POS    0
`define PCR_B_TOUCH_PD   7
`define PCR_B_TOUCH_CKS  6
`define PCR_F_TOUCH_DIV  5:4
`define PCR_F_WAKE_PINS  6:1
`define PCR_B_STAT_CMP   0
`define PCR_B_STAT_WAKE  1
`define PCR_B_STAT_TOUCH_POWERDOWN  2

`endif

/* pkg/pcr_pkg.sv */
package pcr_pkg;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] oe;
    logic [2:0] level;
  } pcr_wave_pins_s;

  typedef struct packed {
    logic       on;
    logic       edge_rise;
    logic       pin_oe;
    logic [1:0] neg_sel;
    logic       pos_sel;
  } pcr_cmp_cfg_s;

  typedef struct packed {
    logic [2:0] cnt;
    logic       tick;
  } pcr_div_s;

  typedef struct packed {
    logic [7:0]     wave_reg;
    logic [7:0]     pawk_reg;
    logic [7:0]     cmp_reg;
    logic [7:0]     pbwk_reg;
    logic [7:0]     touch_reg;
    logic           waitreq;
    logic [31:0]    rdata;
    logic           cmp_prev;
    logic           cmp_event;
    logic           cmp_pin;
    pcr_wave_pins_s wave_pins;
    logic           wake_req;
    logic           src_tick;
  } pcr_state_s;

endpackage : pcr_pkg

/* logic/pcr_prescale.sv */
`timescale 1ns/1ps
`include "pcr_params.svh"

module pcr_prescale (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_en,
  input  wire logic [1:0] i_div_code,
  output logic            o_tick
);

  pcr_pkg::pcr_div_s q;
  pcr_pkg::pcr_div_s d;
  logic [2:0]        limit;

  // ----------------------------------------
  // Divide source ticks by 1, 2, 4 or 8
  // ----------------------------------------
  always_comb begin
    d      = q;
    d.tick = 1'b0;
    limit  = 3'((4'h1 << i_div_code) - 4'h1);
    if (i_en) begin
      if (q.cnt >= limit) begin
        d.cnt  = 3'h0;
        d.tick = 1'b1;
      end else begin
        d.cnt = q.cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_tick = q.tick;

endmodule : pcr_prescale

/* logic/pcr_regs.sv */
`timescale 1ns/1ps
`include "pcr_params.svh"


module pcr_regs #(
  parameter int ADDR_W = 8
) (
  input  wire logic                    i_core_clk,
  input  wire logic                    i_rst_n,
  input  wire logic [ADDR_W-1:0]       i_avs_address,
  input  wire logic                    i_avs_read,
  input  wire logic                    i_avs_write,
  input  wire logic [31:0]             i_avs_writedata,
  input  wire logic [3:0]              i_avs_byteenable,
  output logic      [31:0]             o_avs_readdata,
  output logic                         o_avs_waitrequest,
  input  wire logic [2:0]              i_wave_out,
  input  wire logic                    i_fast_osc_tick,
  input  wire logic [7:0]              i_porta_pins,
  input  wire logic [7:0]              i_portb_pins,
  input  wire logic                    i_cmp_result,
  input  wire logic                    i_touch_data_tick,
  output pcr_pkg::pcr_wave_pins_s      o_wave_pins,
  output logic                         o_wave_clk_sel,
  output logic                         o_wave_src_tick,
  output logic                         o_wave0_tick,
  output logic      [7:0]              o_porta_wake_en,
  output logic      [7:0]              o_portb_wake_en,
  output logic                         o_wake_req,
  output pcr_pkg::pcr_cmp_cfg_s        o_cmp_cfg,
  output logic                         o_cmp_pin,
  output logic                         o_cmp_event,
  output logic                         o_touch_powerdown,
  output logic                         o_touch_clk_sel,
  output logic                         o_touch_data_tick
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  pcr_pkg::pcr_state_s q;
  pcr_pkg::pcr_state_s d;

  logic [5:0]  hit;
  logic        req;
  logic        do_write;
  logic [7:0]  wbyte;
  logic [31:0] rword;
  logic        rise;
  logic        fall;
  logic        wake_a;
  logic        wake_b;

  logic [1:0]  div_en;
  logic [1:0]  div_code [2];
  logic [1:0]  div_tick;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // One-hot: wave, port A wake, comparator, port B wake, touch, status.
  // Low two address bits are ignored; every register is one aligned word.
  function automatic logic [5:0] pcr_decode(input logic [ADDR_W-1:0] a);
    logic [5:0] idx;
    idx = a[7:2];
    pcr_decode = 6'h00;
    pcr_decode[0] = (idx == `PCR_IDX_WAVE);
    pcr_decode[1] = (idx == `PCR_IDX_PAWK);
    pcr_decode[2] = (idx == `PCR_IDX_CMP);
    pcr_decode[3] = (idx == `PCR_IDX_PBWK);
    pcr_decode[4] = (idx == `PCR_IDX_TOUCH);
    pcr_decode[5] = (idx == `PCR_IDX_STAT);
  endfunction : pcr_decode

  // Masked merge keeps reserved bits at their reset value.
  function automatic logic [7:0] pcr_merge(
    input logic [7:0] old_v,
    input logic [7:0] new_v,
    input logic [7:0] mask
  );
    pcr_merge = (old_v & ~mask) | (new_v & mask);
  endfunction : pcr_merge

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    d           = q;
    d.cmp_event = 1'b0;

    req      = i_avs_read | i_avs_write;
    hit      = pcr_decode(i_avs_address);
    do_write = i_avs_write & !q.waitreq & i_avs_byteenable[0];
    wbyte    = i_avs_writedata[7:0];

    // Control registers are write-only and read back as zero;
    // only the status word shows live block state.
    rword = 32'h0000_0000;
    if (hit[5]) begin
      rword[`PCR_B_STAT_CMP]  = q.cmp_prev;
      rword[`PCR_B_STAT_WAKE] = q.wake_req;
      rword[`PCR_B_STAT_TOUCH_POWERDOWN] = q.touch_reg[`PCR_B_TOUCH_PD];
    end

    // One wait cycle: data is captured on the first cycle of a
    // request so it is stable at the edge that completes it.
    if (req && q.waitreq) begin
      d.waitreq = 1'b0;
      d.rdata   = rword;
    end else if (req) begin
      d.waitreq = 1'b1;
    end

    if (do_write) begin
      if (hit[0]) begin
        d.wave_reg = pcr_merge(q.wave_reg, wbyte, `PCR_MASK_WAVE);
      end
      if (hit[1]) begin
        d.pawk_reg = pcr_merge(q.pawk_reg, wbyte, `PCR_MASK_WAKE);
      end
      if (hit[2]) begin
        d.cmp_reg = pcr_merge(q.cmp_reg, wbyte, `PCR_MASK_CMP);
      end
      if (hit[3]) begin
        d.pbwk_reg = pcr_merge(q.pbwk_reg, wbyte, `PCR_MASK_WAKE);
      end
      if (hit[4]) begin
        d.touch_reg = pcr_merge(q.touch_reg, wbyte, `PCR_MASK_TOUCH);
      end
    end

    // ----------------------------------------
    // Waveform pins and clock source
    // ----------------------------------------
    // generator 2 gate
    d.wave_pins.oe[2] = q.wave_reg[`PCR_B_WAVE2_OE];
    d.wave_pins.oe[1] = q.wave_reg[`PCR_B_WAVE1_OE];
    d.wave_pins.oe[0] = q.wave_reg[`PCR_B_WAVE0_OE];
    d.wave_pins.level = i_wave_out & d.wave_pins.oe;

    // clock source select
    // The system clock is the block clock, so it ticks every cycle.
    d.src_tick = q.wave_reg[`PCR_B_WAVE_CKS] ? i_fast_osc_tick : 1'b1;

    // ----------------------------------------
    // Wake-up
    // ----------------------------------------
    // port A low level
    wake_a = |(q.pawk_reg[`PCR_F_WAKE_PINS] & ~i_porta_pins[`PCR_F_WAKE_PINS]);
    wake_b = |(q.pbwk_reg[`PCR_F_WAKE_PINS] & ~i_portb_pins[`PCR_F_WAKE_PINS]);
    d.wake_req = wake_a | wake_b;

    // ----------------------------------------
    // Comparator
    // ----------------------------------------
    rise       = i_cmp_result & ~q.cmp_prev;
    fall       = ~i_cmp_result & q.cmp_prev;
    d.cmp_prev = i_cmp_result;
    if (q.cmp_reg[`PCR_B_CMP_ON]) begin
      d.cmp_event = q.cmp_reg[`PCR_B_CMP_EDGE] ? rise : fall;
    end
    d.cmp_pin = i_cmp_result & q.cmp_reg[`PCR_B_CMP_ON]
              & q.cmp_reg[`PCR_B_CMP_OE];
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      q           <= '0;
      q.waitreq   <= 1'b1;
      q.wave_reg  <= `PCR_RST_WAVE;
      q.pawk_reg  <= `PCR_RST_WAKE;
      q.cmp_reg   <= `PCR_RST_CMP;
      q.pbwk_reg  <= `PCR_RST_WAKE;
      q.touch_reg <= `PCR_RST_TOUCH;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Prescalers
  // ----------------------------------------
  // Index 0 divides the waveform source, index 1 the touch data.
  // generator 0 divider
  assign div_en[0]   = q.src_tick;
  assign div_code[0] = q.wave_reg[`PCR_F_WAVE0_DIV];
  // touch data divider
  // Powered-down touch unit produces no data ticks.
  assign div_en[1]   = i_touch_data_tick & ~q.touch_reg[`PCR_B_TOUCH_PD];
  assign div_code[1] = q.touch_reg[`PCR_F_TOUCH_DIV];

  generate
    for (genvar g = 0; g < 2; g++) begin : g_div
      pcr_prescale u_div (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_en       (div_en[g]),
        .i_div_code (div_code[g]),
        .o_tick     (div_tick[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_avs_readdata    = q.rdata;
  assign o_avs_waitrequest = q.waitreq;
  assign o_wave_pins       = q.wave_pins;
  assign o_wave_clk_sel    = q.wave_reg[`PCR_B_WAVE_CKS];
  assign o_wave_src_tick   = q.src_tick;
  assign o_wave0_tick      = div_tick[0];
  assign o_porta_wake_en   = q.pawk_reg;
  assign o_portb_wake_en   = q.pbwk_reg;
  assign o_wake_req        = q.wake_req;

  assign o_cmp_cfg.on        = q.cmp_reg[`PCR_B_CMP_ON];
  assign o_cmp_cfg.edge_rise = q.cmp_reg[`PCR_B_CMP_EDGE];
  assign o_cmp_cfg.pin_oe    = q.cmp_reg[`PCR_B_CMP_OE];
  // negative input code
  // Code 0x is ground, 10 first pin, 11 second pin.
  assign o_cmp_cfg.neg_sel   = q.cmp_reg[`PCR_F_CMP_NEG];
  assign o_cmp_cfg.pos_sel   = q.cmp_reg[`PCR_B_CMP_POS];
  assign o_cmp_pin           = q.cmp_pin;
  assign o_cmp_event         = q.cmp_event;

  assign o_touch_powerdown = q.touch_reg[`PCR_B_TOUCH_PD];
  assign o_touch_clk_sel   = q.touch_reg[`PCR_B_TOUCH_CKS];
  assign o_touch_data_tick = div_tick[1];

endmodule : pcr_regs

/* dv/pcr_regs_sva.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Checker
// ----------------------------------------
module pcr_regs_sva (
  input wire logic                  i_core_clk,
  input wire logic                  i_rst_n,
  input wire logic                  o_avs_waitrequest,
  input wire logic [2:0]            i_wave_out,
  input wire logic                  i_fast_osc_tick,
  input wire logic [7:0]            i_porta_pins,
  input wire logic [7:0]            i_portb_pins,
  input wire logic                  i_cmp_result,
  input wire pcr_pkg::pcr_wave_pins_s o_wave_pins,
  input wire logic                  o_wave_clk_sel,
  input wire logic                  o_wave_src_tick,
  input wire logic [7:0]            o_porta_wake_en,
  input wire logic [7:0]            o_portb_wake_en,
  input wire logic                  o_wake_req,
  input wire pcr_pkg::pcr_cmp_cfg_s o_cmp_cfg,
  input wire logic                  o_cmp_pin,
  input wire logic                  o_cmp_event,
  input wire logic                  o_touch_powerdown,
  input wire logic                  o_touch_data_tick
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  a_wait_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low two cycles");
  a_wave_level: assert property ($past(i_rst_n) && $stable(o_wave_pins.oe) |->
    o_wave_pins.level == ($past(i_wave_out) & o_wave_pins.oe)) else $error("wave pin level wrong");
  a_src_tick: assert property ($past(i_rst_n) && o_wave_clk_sel == $past(o_wave_clk_sel) |->
    o_wave_src_tick == (o_wave_clk_sel ? $past(i_fast_osc_tick) : 1'b1)) else $error("source tick wrong");
  a_wake_req: assert property (o_wake_req == $past(|((~i_porta_pins & o_porta_wake_en)
    | (~i_portb_pins & o_portb_wake_en)))) else $error("wake request wrong");
  a_wake_rsvd: assert property (!o_porta_wake_en[7] && !o_porta_wake_en[0]
    && !o_portb_wake_en[7] && !o_portb_wake_en[0]) else $error("reserved wake bit set");
  a_cmp_pin: assert property (o_cmp_pin == $past(i_cmp_result & o_cmp_cfg.on & o_cmp_cfg.pin_oe))
    else $error("comparator pin wrong");
  a_cmp_edge: assert property (o_cmp_event |-> $past(o_cmp_cfg.on)
    && $past(i_cmp_result) == $past(o_cmp_cfg.edge_rise) && $past(i_cmp_result) != $past(i_cmp_result, 2))
    else $error("comparator event wrong");
  a_touch_off: assert property (o_touch_data_tick |-> !$past(o_touch_powerdown))
    else $error("touch tick while powered down");
endmodule : pcr_regs_sva

bind pcr_regs pcr_regs_sva u_sva (.i_core_clk, .i_rst_n, .o_avs_waitrequest, .i_wave_out, .i_fast_osc_tick,
  .i_porta_pins, .i_portb_pins, .i_cmp_result, .o_wave_pins, .o_wave_clk_sel, .o_wave_src_tick,
  .o_porta_wake_en, .o_portb_wake_en, .o_wake_req, .o_cmp_cfg, .o_cmp_pin, .o_cmp_event,
  .o_touch_powerdown, .o_touch_data_tick);

/* dv/pcr_regs_test.sv */
`timescale 1ns/1ps
module pcr_regs_test;
  logic                    clk, rst_n, rd, wr, fosc, cmp, ttk, wrq, wcs, wst, w0t, wreq, cpin, cev, tpd, tcs, ttko;
  logic [7:0]              addr, pa, pb, pawe, pbwe, d;
  logic [31:0]             wd, rdo, r;
  logic [3:0]              be;
  logic [2:0]              wo;
  logic                    b;
  pcr_pkg::pcr_wave_pins_s wp;
  pcr_pkg::pcr_cmp_cfg_s   ccfg;
  logic [7:0]              m [5];
  int                      fail_count, checks, cyc, n, k, c;
  localparam logic [7:0]   ADR [5] = '{8'h44, 8'h4c, 8'h5c, 8'h60, 8'h74};
  localparam logic [7:0]   MSK [5] = '{8'h3f, 8'h7e, 8'hf9, 8'h7e, 8'hf0};

  pcr_regs DUT (.i_core_clk(clk), .i_rst_n(rst_n), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdo), .o_avs_waitrequest(wrq),
    .i_wave_out(wo), .i_fast_osc_tick(fosc), .i_porta_pins(pa), .i_portb_pins(pb), .i_cmp_result(cmp),
    .i_touch_data_tick(ttk), .o_wave_pins(wp), .o_wave_clk_sel(wcs), .o_wave_src_tick(wst),
    .o_wave0_tick(w0t), .o_porta_wake_en(pawe), .o_portb_wake_en(pbwe), .o_wake_req(wreq),
    .o_cmp_cfg(ccfg), .o_cmp_pin(cpin), .o_cmp_event(cev), .o_touch_powerdown(tpd),
    .o_touch_clk_sel(tcs), .o_touch_data_tick(ttko));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Free-running random pin stimulus keeps the checker busy
  always @(posedge clk) begin
    cyc <= cyc + 1;
    wo <= 3'($urandom);
    pa <= 8'($urandom);
    pb <= 8'($urandom);
    cmp <= 1'($urandom);
    fosc <= 1'($urandom);
    if (cyc == 30000) begin
      fail_count++;
      final_report();
    end
  end

  // Reserved bits keep their value whatever is written
  function automatic logic [7:0] exp_merge(input logic [7:0] old_v, input logic [7:0] new_v, input logic [7:0] msk);
    return (old_v & ~msk) | (new_v & msk);
  endfunction : exp_merge

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task bus(input logic we, input logic [7:0] a, input logic [7:0] dv, input logic bev, output logic [31:0] rv);
    @(posedge clk);
    addr <= a;
    wd <= {24'h0000_00, dv};
    be <= {3'h0, bev};
    wr <= we;
    rd <= !we;
    @(posedge clk);
    while (wrq !== 1'b0) @(posedge clk);
    rv = rdo;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task chk_regs;
    chk(wp.oe, {m[0][5], m[0][3], m[0][2]});
    chk(wcs, m[0][4]);
    chk(pawe, m[1] & 8'h7e);
    chk(pbwe, m[3] & 8'h7e);
    chk(ccfg, {m[2][7:3], m[2][0]});
    chk(tpd, m[4][7]);
    chk(tcs, m[4][6]);
  endtask : chk_regs

  task do_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    m = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hc0};
    @(posedge clk);
    chk_regs();
    $display("test reset done");
  endtask : do_reset

  task final_report;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report

  initial begin
    {rst_n, rd, wr, fosc, cmp, ttk, addr, wd, be, wo} = '0;
    pa = 8'hff;
    pb = 8'hff;
    fail_count = 0;
    checks = 0;
    cyc = 0;
    void'($urandom(32'h554c));
    do_reset();
    // Corner cases: all ones, then all zeros, into every control register
    for (c = 0; c < 2; c++) begin
      for (k = 0; k < 5; k++) begin
        bus(1'b1, ADR[k], (c == 0) ? 8'hff : 8'h00, 1'b1, r);
        m[k] = exp_merge(m[k], (c == 0) ? 8'hff : 8'h00, MSK[k]);
      end
      repeat (2) @(posedge clk);
      chk_regs();
    end
    // A write must show on the register output at the very next edge
    bus(1'b1, ADR[1], 8'h5a, 1'b1, r);
    m[1] = exp_merge(m[1], 8'h5a, MSK[1]);
    @(posedge clk);
    chk(pawe, m[1]);
    $display("test corner writes done");
    // Random writes, one in six to an unmapped place, some with byte lane off
    repeat (60) begin
      k = $urandom_range(5, 0);
      d = 8'($urandom);
      b = 1'($urandom);
      bus(1'b1, (k == 5) ? 8'h48 : ADR[k], d, b, r);
      if (k < 5 && b)
        m[k] = exp_merge(m[k], d, MSK[k]);
      bus(1'b0, (k == 5) ? 8'h48 : ADR[k], 8'h00, 1'b1, r);
      chk(r, 32'h0000_0000);
      bus(1'b0, 8'h7c, 8'h00, 1'b1, r);
      chk(r[2], m[4][7]);
      repeat (2) @(posedge clk);
      chk_regs();
    end
    $display("test random writes done");
    // Divider codes: any 64-cycle window holds 64/div output pulses
    for (c = 0; c < 4; c++) begin
      bus(1'b1, 8'h44, 8'(c), 1'b1, r);
      bus(1'b1, 8'h74, 8'(c << 4), 1'b1, r);
      repeat (4) @(posedge clk);
      n = 0;
      repeat (64) begin
        @(posedge clk);
        n += int'(w0t);
      end
      chk(n, 64 >> c);
      n = 0;
      ttk <= 1'b1;
      repeat (64) begin
        @(posedge clk);
        n += int'(ttko);
      end
      ttk <= 1'b0;
      repeat (6) begin
        @(posedge clk);
        n += int'(ttko);
      end
      chk(n, 64 >> c);
    end
    $display("test dividers done");
    do_reset();
    final_report();
  end
endmodule : pcr_regs_test
